// ### core/smc_pkg.sv
// constants for the serial management host controller
package smc_pkg;

  // system clock and the fastest management clock the device accepts
  localparam int SYS_CLK_MHZ      = 100;
  localparam int MGMT_CLK_MAX_MHZ = 25;
  // a bit must last at least one full management clock period
  localparam int BIT_CYCLES =
    (SYS_CLK_MHZ + MGMT_CLK_MAX_MHZ - 1) / MGMT_CLK_MAX_MHZ;
  localparam int HALF_CYCLES = BIT_CYCLES / 2;
  localparam logic [1:0] PH_LAST = 2'(BIT_CYCLES - 1);
  localparam logic [1:0] PH_HIGH = 2'(HALF_CYCLES);

  // frame layout: preamble, then 48 bits from start pattern to data end
  localparam logic [5:0] PRE_LAST   = 6'd34;
  localparam logic [5:0] FRAME_LAST = 6'd47;
  localparam logic [5:0] TA_IDX     = 6'd14;
  localparam logic [5:0] DATA_IDX   = 6'd16;
  localparam logic [1:0] START_PAT  = 2'b01;
  localparam logic [1:0] OP_READ    = 2'b10;
  localparam logic [1:0] OP_WRITE   = 2'b01;
  localparam logic [1:0] UNUSED_PAT = 2'b00;
  localparam logic [1:0] TA_WRITE   = 2'b10;
  localparam logic [1:0] TA_READ    = 2'b11;

  // registers of the device behind the link (6-bit register addresses)
  localparam logic [5:0] DEV_IRQ_STATUS = 6'h10;
  localparam logic [5:0] DEV_IRQ_MASK   = 6'h11;
  localparam logic [5:0] DEV_INDIRECT   = 6'h13;

  // controller registers, byte addresses on the bus
  localparam logic [7:0] REG_CMD      = 8'h00;
  localparam logic [7:0] REG_WDATA    = 8'h04;
  localparam logic [7:0] REG_RDATA    = 8'h08;
  localparam logic [7:0] REG_STATUS   = 8'h0c;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK = 8'h14;

  // command register fields
  localparam int CMD_START  = 0;
  localparam int CMD_READ   = 1;
  localparam int CMD_PRE    = 2;
  localparam int CMD_ID_LO  = 4;
  localparam int CMD_ADR_LO = 8;
  localparam logic [31:0] CMD_STORE_MASK = 32'h0000_3f36;

  // status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_INIT = 1;

  // interrupt status / mask fields
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_REFUSE = 1;
  localparam int IRQ_DEV    = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;

endpackage : smc_pkg

// ### core/smc_sync2.sv
// two flip-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module smc_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : smc_sync2

// ### core/smc_bit_timer.sv
// bit-phase divider that also makes the management clock
`timescale 1ns/1ps
module smc_bit_timer
  import smc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  output logic      [1:0] phase_q,
  output logic            mgmt_clk_q
);
  logic [1:0] phase_d;

  always_comb begin
    phase_d = (phase_q == PH_LAST) ? 2'h0 : phase_q + 2'h1;
  end

  // low in the first half of each bit, high in the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q    <= 2'h0;
      mgmt_clk_q <= 1'b0;
    end else begin
      phase_q    <= phase_d;
      mgmt_clk_q <= (phase_d >= PH_HIGH);
    end
  end
endmodule : smc_bit_timer

// ### core/smc_host_top.sv
// serial management host: bus registers, frame engine and interrupt
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
// Behaviour
// R01 - link is one clock we drive plus one shared two-way data line
// R02 - management clock never faster than 25 MHz
// R03 - first frame after reset is always preceded by a preamble
// R04 - preamble is 35 consecutive ones, one clock per bit
// R05 - every frame opens with start pattern 01
// R06 - opcode 10 reads, 01 writes
// R07 - ten address bits follow, most significant first
// R08 - address is 2-bit select id, 00, then 6-bit register
// R09 - turnaround: released on reads, 10 driven on writes
// R10 - 32 data bits: device drives on reads, we drive on writes
// R11 - after the first preamble, frames may omit it
// R12 - at least one idle bit with line high between frames
// R13 - device acts only on matching select id, else stays off the line
// R14 - indirect word read: write address and command to 13, read back
// R15 - device interrupt follows its status and mask registers 10 and 11
// R16 - indirect word write: address and data through register 13
// R17 - device samples on rising edge; read bits valid by next rise
// R18 - device waits for a new start after 32nd data bit or mismatch
module smc_host_top
  import smc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_wr,
  output logic      [31:0] wb_dat_rd,
  output logic             wb_ack,
  output logic             serial_mgmt_clock, // [R01]
  input  wire logic        mgmt_data_in,
  output logic             mgmt_data_out,
  output logic             mgmt_data_oe,
  input  wire logic        dev_irq_n,
  output logic             irq
);
  typedef enum logic [1:0] {SMC_IDLE, SMC_PRE, SMC_FRAME, SMC_GAP} smc_state_e;

  smc_state_e  state_q;
  logic        rst_meta_q;
  logic        rst_n;
  logic [1:0]  phase;
  logic        bit_end;
  logic [1:0]  sync_out;
  logic        data_sync;
  logic        dev_irq_sync;
  logic        dev_irq_prev_q;
  logic [31:0] cmd_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic [47:0] shift_q;
  logic [5:0]  cnt_q;
  logic        go_q;
  logic        init_done_q;
  logic        cur_read_q;
  logic [2:0]  irq_stat_q;
  logic [2:0]  irq_mask_q;
  logic        bus_req;
  logic        bus_wr;
  logic [31:0] cmd_merged;
  logic        start_req;
  logic        busy;
  logic        frame_done;
  logic [2:0]  irq_set;
  logic [2:0]  irq_clr;
  logic [2:0]  irq_stat_d;
  logic [47:0] frame_word;

  function automatic logic [31:0] sel_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : sel_merge

  // reset release through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  smc_bit_timer u_timer (
    .clk        (clk),
    .rst_n      (rst_n),
    .phase_q    (phase),
    .mgmt_clk_q (serial_mgmt_clock)
  );

  smc_sync2 #(.WIDTH(2)) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({~dev_irq_n, mgmt_data_in}),
    .sync_out (sync_out)
  );

  assign data_sync    = sync_out[0];
  assign dev_irq_sync = sync_out[1];
  // last cycle of a bit: data sampled here was seen before the rising edge
  assign bit_end      = (phase == PH_LAST); // [R02] [R17]
  assign busy         = go_q || (state_q != SMC_IDLE);

  // ---------------- bus slave ----------------
  assign bus_req    = wb_cyc && wb_stb && !wb_ack;
  assign bus_wr     = bus_req && wb_we;
  assign cmd_merged = sel_merge(cmd_q, wb_dat_wr, wb_sel);
  assign start_req  = bus_wr && (wb_adr == REG_CMD) && cmd_merged[CMD_START];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack    <= 1'b0;
      wb_dat_rd <= 32'h0;
    end else begin
      wb_ack <= bus_req;
      if (bus_req && !wb_we) begin
        unique case (wb_adr)
          REG_CMD:      wb_dat_rd <= cmd_q;
          REG_WDATA:    wb_dat_rd <= wdata_q;
          REG_RDATA:    wb_dat_rd <= rdata_q;
          REG_STATUS:   wb_dat_rd <= {30'h0, init_done_q, busy};
          REG_IRQ_STAT: wb_dat_rd <= {29'h0, irq_stat_q};
          REG_IRQ_MASK: wb_dat_rd <= {29'h0, irq_mask_q};
          default:      wb_dat_rd <= 32'h0;
        endcase
      end
    end
  end

  // command and write data are frozen while a frame runs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q   <= 32'h0;
      wdata_q <= 32'h0;
    end else if (bus_wr && !busy) begin
      if (wb_adr == REG_CMD) begin
        cmd_q <= cmd_merged & CMD_STORE_MASK;
      end
      if (wb_adr == REG_WDATA) begin
        wdata_q <= sel_merge(wdata_q, wb_dat_wr, wb_sel);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_q <= IRQ_RESET;
    end else if (bus_wr && wb_adr == REG_IRQ_MASK && wb_sel[0]) begin
      irq_mask_q <= wb_dat_wr[2:0];
    end
  end

  // ---------------- frame engine ----------------
  // start, opcode, select id, unused, register address, turnaround, data
  always_comb begin
    frame_word = {START_PAT,                                  // [R05]
                  cmd_q[CMD_READ] ? OP_READ : OP_WRITE,       // [R06]
                  cmd_q[CMD_ID_LO +: 2], UNUSED_PAT,          // [R08]
                  cmd_q[CMD_ADR_LO +: 6],                     // [R07]
                  cmd_q[CMD_READ] ? TA_READ : TA_WRITE,       // [R09]
                  wdata_q};                                   // [R10] [R16]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      go_q <= 1'b0;
    end else if (start_req && !busy) begin
      go_q <= 1'b1;
    end else if (state_q == SMC_IDLE && bit_end) begin
      go_q <= 1'b0;
    end
  end

  assign frame_done = (state_q == SMC_FRAME) && bit_end &&
                      (cnt_q == FRAME_LAST);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q       <= SMC_IDLE;
      cnt_q         <= 6'h0;
      shift_q       <= 48'h0;
      cur_read_q    <= 1'b0;
      mgmt_data_out <= 1'b1;
      mgmt_data_oe  <= 1'b0;
    end else if (bit_end) begin
      unique case (state_q)
        SMC_IDLE: begin
          if (go_q) begin
            cur_read_q <= cmd_q[CMD_READ];
            cnt_q      <= 6'h0;
            if (cmd_q[CMD_PRE] || !init_done_q) begin // [R03] [R11]
              state_q       <= SMC_PRE;
              mgmt_data_out <= 1'b1;                   // [R04]
              mgmt_data_oe  <= 1'b1;
            end else begin
              state_q       <= SMC_FRAME;
              shift_q       <= {frame_word[46:0], 1'b0};
              mgmt_data_out <= frame_word[47];
              mgmt_data_oe  <= 1'b1;
            end
          end
        end
        SMC_PRE: begin
          if (cnt_q == PRE_LAST) begin                 // [R04]
            state_q       <= SMC_FRAME;
            cnt_q         <= 6'h0;
            shift_q       <= {frame_word[46:0], 1'b0};
            mgmt_data_out <= frame_word[47];
          end else begin
            cnt_q <= cnt_q + 6'h1;
          end
        end
        SMC_FRAME: begin
          if (cnt_q == FRAME_LAST) begin
            state_q       <= SMC_GAP;                  // [R12]
            mgmt_data_out <= 1'b1;
            mgmt_data_oe  <= 1'b0;
          end else begin
            cnt_q         <= cnt_q + 6'h1;
            shift_q       <= {shift_q[46:0], 1'b0};
            mgmt_data_out <= shift_q[47];
            // release the line for turnaround and data of a read
            mgmt_data_oe  <= !(cur_read_q &&
                               (cnt_q + 6'h1) >= TA_IDX); // [R09] [R10]
          end
        end
        SMC_GAP: begin
          state_q <= SMC_IDLE;                         // [R12]
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_done_q <= 1'b0;
    end else if (state_q == SMC_PRE && bit_end && cnt_q == PRE_LAST) begin
      init_done_q <= 1'b1;                             // [R03]
    end
  end

  // read data shifted in msb first; indirect words land in bits 15:0
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0;
    end else if (state_q == SMC_FRAME && bit_end && cur_read_q &&
                 cnt_q >= DATA_IDX) begin
      rdata_q <= {rdata_q[30:0], data_sync};           // [R10] [R14] [R17]
    end
  end

  // ---------------- interrupts ----------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_irq_prev_q <= 1'b0;
    end else begin
      dev_irq_prev_q <= dev_irq_sync;
    end
  end

  always_comb begin
    irq_set             = 3'h0;
    irq_set[IRQ_DONE]   = frame_done;
    irq_set[IRQ_REFUSE] = start_req && busy;
    irq_set[IRQ_DEV]    = dev_irq_sync && !dev_irq_prev_q;      // [R15]
    irq_clr = (bus_wr && wb_adr == REG_IRQ_STAT && wb_sel[0]) ?
              wb_dat_wr[2:0] : 3'h0;
    irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;  // set wins over clear
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= IRQ_RESET;
      irq       <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq        <= |(irq_stat_d & irq_mask_q);
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_clk_high;
    serial_mgmt_clock [*2];
  endsequence
  sequence s_gap_bit;
    (state_q == SMC_GAP && !mgmt_data_oe) [*4];
  endsequence
  chk_clk_rate: assert property ( // [R02]
    $rose(serial_mgmt_clock) |-> s_clk_high ##1 !serial_mgmt_clock [*2])
    else $error("management clock high or low phase too short");
  chk_preamble_first: assert property ( // [R03]
    (state_q == SMC_IDLE && go_q && bit_end && !init_done_q)
      |=> state_q == SMC_PRE)
    else $error("first frame started without preamble");
  chk_preamble_ones: assert property ( // [R04]
    state_q == SMC_PRE |-> mgmt_data_out && mgmt_data_oe)
    else $error("preamble bit not a driven one");
  chk_start_pattern: assert property ( // [R05]
    $rose(state_q == SMC_FRAME) |-> !mgmt_data_out [*4] ##1 mgmt_data_out)
    else $error("start pattern is not 01");
  chk_opcode_bit: assert property ( // [R06]
    (state_q == SMC_FRAME && cnt_q == 6'd2) |-> mgmt_data_out == cur_read_q)
    else $error("opcode first bit wrong");
  chk_unused_zero: assert property ( // [R08]
    (state_q == SMC_FRAME && (cnt_q == 6'd6 || cnt_q == 6'd7))
      |-> !mgmt_data_out)
    else $error("unused address bits not zero");
  chk_read_release: assert property ( // [R09]
    (state_q == SMC_FRAME && cur_read_q && cnt_q >= TA_IDX) |-> !mgmt_data_oe)
    else $error("line driven during read turnaround or data");
  chk_write_ta: assert property ( // [R09]
    (state_q == SMC_FRAME && !cur_read_q && cnt_q == TA_IDX)
      |-> mgmt_data_out && mgmt_data_oe ##4 !mgmt_data_out)
    else $error("write turnaround is not 10");
  chk_idle_gap: assert property ( // [R12]
    frame_done |=> s_gap_bit ##1 state_q == SMC_IDLE)
    else $error("idle bit between frames missing");
  chk_bus_ack: assert property (
    $rose(wb_ack) |=> !wb_ack)
    else $error("bus acknowledge longer than one cycle");
endmodule : smc_host_top

// ### verification/smc_dev_model.sv
// behavioural model of the managed device on the serial link
`timescale 1ns/1ps
module smc_dev_model #(
  parameter logic [1:0] SELF_ID = 2'h1
) (
  input  wire logic        rst_n,
  input  wire logic        mclk,
  input  wire logic        line,
  input  wire logic [31:0] ev,
  output logic             drv_oe,
  output logic             drv_out,
  output logic             irq_n,
  output logic [5:0]       pre_ones
);
  logic [31:0] status_q, mask_q, ind_q, rd_word;
  logic [15:0] cfg [64];
  logic [47:0] sh;
  logic [5:0]  ones, idx, reg_a;
  logic [1:0]  op;
  logic        init_q, busy, rd_go, hit;

  assign irq_n = ~|(status_q & mask_q);

  // indirect word layout: [31:30] 01 write, 10 fetch; [21:16] word; [15:0]
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {ones, idx, reg_a, op, pre_ones} = '0;
      {init_q, busy, rd_go, hit} = '0;
      {status_q, mask_q, ind_q, rd_word, sh} = '0;
      foreach (cfg[i]) cfg[i] = 16'h0;
    end else begin
      status_q = status_q | ev;
      if (!busy) begin
        if (line) ones = (ones == 6'h3f) ? ones : ones + 6'h1;
        else if (init_q || ones >= 6'd35) begin
          {init_q, busy, idx, sh, pre_ones} = {2'b11, 6'h1, 48'h0, ones};
        end else ones = 6'h0;
      end else begin
        sh = {sh[46:0], line};
        idx = idx + 6'h1;
        if (idx == 6'd14) begin
          op = sh[11:10];
          reg_a = sh[5:0];
          hit = sh[12] && sh[7:6] == 2'b00 && sh[9:8] == SELF_ID;
          rd_go = hit && op == 2'b10;
          rd_word = reg_a == 6'h10 ? status_q : reg_a == 6'h11 ? mask_q
                  : reg_a == 6'h13 ? ind_q : 32'h0;
          if (rd_go && reg_a == 6'h10) status_q = 32'h0;
        end
        if (idx == 6'd48) begin
          if (hit && op == 2'b01 && reg_a == 6'h11) mask_q = sh[31:0];
          if (hit && op == 2'b01 && reg_a == 6'h13) begin
            if (sh[31:30] == 2'b01) cfg[sh[21:16]] = sh[15:0];
            if (sh[31:30] == 2'b10) ind_q = {16'h0, cfg[sh[21:16]]};
          end
          {busy, rd_go, hit, ones} = '0;
        end
      end
    end
  end

  // drive after the falling edge so bits are valid at the next rise
  always @(negedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drv_oe <= 1'b0;
      drv_out <= 1'b1;
    end else if (rd_go && idx >= 6'd15 && idx <= 6'd47) begin
      drv_oe <= 1'b1;
      drv_out <= (idx == 6'd15) ? 1'b0 : rd_word[47-idx];
    end else begin
      drv_oe <= 1'b0;
      drv_out <= 1'b1;
    end
  end
endmodule : smc_dev_model

// ### verification/smc_host_top_bench.sv
// self-checking bench for the serial management host controller
`timescale 1ns/1ps
module smc_host_top_bench
  import smc_pkg::*;
;
  logic        clk, reset_n, wb_cyc, wb_stb, wb_we, wb_ack, irq;
  logic        mclk, d_out, d_oe, dev_oe, dev_out, dev_irq_n;
  logic        mc_d = 1'b0, zero_q = 1'b0;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat_wr, wb_dat_rd, dev_ev, rd;
  logic [5:0]  pre_ones;
  int          err_count, n_checks, n;
  int          gap = 0, run = 0, pre_run = 0;
  wire         line = d_oe ? d_out : (dev_oe ? dev_out : 1'b1);

  smc_host_top uut (.clk(clk), .reset_n(reset_n), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
    .wb_dat_wr(wb_dat_wr), .wb_dat_rd(wb_dat_rd), .wb_ack(wb_ack),
    .serial_mgmt_clock(mclk), .mgmt_data_in(line), .mgmt_data_out(d_out),
    .mgmt_data_oe(d_oe), .dev_irq_n(dev_irq_n), .irq(irq));
  smc_dev_model dev (.rst_n(reset_n), .mclk(mclk), .line(line),
    .ev(dev_ev), .drv_oe(dev_oe), .drv_out(dev_out), .irq_n(dev_irq_n),
    .pre_ones(pre_ones));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic fail(input string m);
    err_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask : fail

  task automatic check(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", m, got, exp));
  endtask : check

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_wr} <= {2'b11, we, a, d};
    do begin
      @(posedge clk);
      k++;
    end while (wb_ack !== 1'b1 && k < 20);
    rd = wb_dat_rd;
    {wb_cyc, wb_stb} <= 2'b00;
    if (k >= 20) begin
      fail("no ack");
      tally_and_finish;
    end
  endtask : wb

  task automatic wait_idle;
    int k;
    k = 0;
    repeat (6) @(posedge clk);
    do begin
      wb(0, REG_STATUS, 0);
      k++;
    end while (rd[ST_BUSY] !== 1'b0 && k < 200);
    if (k >= 200) begin
      fail("frame hang");
      tally_and_finish;
    end
  endtask : wait_idle

  task automatic cmd(input logic r, input logic [1:0] id, input logic [5:0] a);
    wb(1, REG_CMD, 32'(a) << CMD_ADR_LO | 32'(id) << CMD_ID_LO
                 | 32'(r) << CMD_READ | 32'h1);
  endtask : cmd

  task automatic frame(input logic r, input logic [1:0] id,
                       input logic [5:0] a, input logic [31:0] d);
    if (!r) wb(1, REG_WDATA, d);
    cmd(r, id, a);
    wait_idle();
    if (r) wb(0, REG_RDATA, 0);
  endtask : frame

  // wire monitor: clock spacing and length of the driven preamble
  always @(posedge clk) begin
    mc_d <= mclk;
    gap <= gap + 1;
    if (mclk && !mc_d) begin
      gap <= 0;
      if (gap < 3) fail("mgmt clock too fast");
      if (!d_oe) begin
        run <= 0;
        zero_q <= 1'b0;
      end else if (d_out) run <= run + 1;
      else if (!zero_q) begin
        pre_run <= run;
        zero_q <= 1'b1;
      end
    end
  end

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  initial begin
    {reset_n, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_wr, dev_ev} = '0;
    {err_count, n_checks} = '0;
    wb_sel = 4'hf;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    wb(0, REG_STATUS, 0);
    check(rd, 32'h0, "status at reset");
    wb(0, 8'h1c, 0);
    check(rd, 32'h0, "unmapped read");
    check({31'h0, irq}, 32'h0, "irq at reset");
    $display("test reset done");
    frame(0, 2'h1, DEV_IRQ_MASK, 32'h0000_0005);
    check(dev.mask_q, 32'h5, "device write");
    check(32'(pre_run), 32'd35, "preamble length");
    wb(0, REG_STATUS, 0);
    check(rd, 32'h2, "init flag");
    frame(1, 2'h1, DEV_IRQ_MASK, 0);
    check(rd, 32'h5, "read back");
    check(32'(pre_run), 32'd0, "suppressed preamble");
    check(32'(pre_ones != 0), 32'h1, "idle bit");
    $display("test write read done");
    frame(1, 2'h2, DEV_IRQ_MASK, 0);
    check(rd, 32'hffff_ffff, "foreign id");
    frame(1, 2'h1, DEV_IRQ_MASK, 0);
    check(rd, 32'h5, "after mismatch");
    $display("test select done");
    frame(0, 2'h1, DEV_INDIRECT, 32'h4005_1234);
    frame(0, 2'h1, DEV_INDIRECT, 32'h8005_0000);
    frame(1, 2'h1, DEV_INDIRECT, 0);
    check({16'h0, rd[15:0]}, 32'h1234, "indirect word");
    wb(1, REG_WDATA, 32'h0000_0005);
    wb(1, REG_CMD, 32'(DEV_IRQ_MASK) << CMD_ADR_LO | 32'h1 << CMD_ID_LO
                 | 32'h1 << CMD_PRE | 32'h1 << CMD_START);
    wait_idle();
    check(32'(pre_run), 32'd35, "forced preamble");
    check(dev.mask_q, 32'h5, "write after preamble");
    $display("test indirect done");
    wb(1, REG_IRQ_STAT, 32'h7);
    cmd(1, 2'h1, DEV_IRQ_MASK);
    cmd(1, 2'h1, DEV_IRQ_MASK);
    wait_idle();
    wb(0, REG_IRQ_STAT, 0);
    check(rd, 32'h3, "refused start");
    wb(1, REG_IRQ_STAT, 32'h7);
    wb(1, REG_IRQ_MASK, 32'h4);
    dev_ev <= 32'h4;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (irq !== 1'b1 && n < 100);
    check({31'h0, irq}, 32'h1, "device interrupt");
    wb(0, REG_IRQ_STAT, 0);
    check(rd, 32'h4, "irq status");
    wb(1, REG_IRQ_MASK, 32'h0);
    @(posedge clk);
    check({31'h0, irq}, 32'h0, "masked");
    wb(1, REG_IRQ_MASK, 32'h4);
    wb(1, REG_IRQ_STAT, 32'h4);
    @(posedge clk);
    check({31'h0, irq}, 32'h0, "cleared");
    dev_ev <= 32'h0;
    frame(1, 2'h1, DEV_IRQ_STATUS, 0);
    check(rd, 32'h4, "device status");
    $display("test interrupt done");
    tally_and_finish;
  end
endmodule : smc_host_top_bench
